/* inc/mulneg_params.svh */
/*
  Offsets, field positions, reset values, opcode patterns and addressing limits
  of the multiply and negate execution unit. Assumes it is included by bare name.
*/
`ifndef MULNEG_PARAMS_SVH
`define MULNEG_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL      12'h000
`define OFS_WREG      12'h004
`define OFS_BANKSEL   12'h008
`define OFS_STATUS    12'h00C
`define OFS_PROD_LO   12'h010
`define OFS_PROD_HI   12'h014
`define OFS_INSTR     12'h018
`define OFS_MEM_ADDR  12'h01C
`define OFS_MEM_DATA  12'h020
`define OFS_IDX_BASE  12'h024

// ****************************************
// Fields and reset values
// ****************************************
`define CTRL_EXT_BIT  0
`define FLG_C         0
`define FLG_DIGIT     1
`define FLG_Z         2
`define FLG_OVERFLOW  3
`define FLG_N         4
`define INSTR_BUSY    16
`define INSTR_ILLEGAL 17
`define RST_BYTE      8'h00
`define RST_FLAGS     5'h00
`define RST_ADDR      12'h000
`define RST_OP        16'h0000

// ****************************************
// Opcode patterns and addressing limits
// ****************************************
`define OPC_MULL_HI   8'h0D
`define OPC_MULF_HI   7'h01
`define OPC_NEG_HI    7'h36
`define OPC_NOP_TOP   4'hF
`define ACC_SPLIT     8'h60
`define LIT_LIMIT     8'h5F
`define ACC_LOW_BANK  4'h0
`define ACC_HIGH_BANK 4'hF
`define MEM_DEPTH     4096

`endif

/* inc/mulneg_pkg.sv */
/*
  Types of the multiply and negate execution unit.
  Assumes nothing of its surroundings.
*/
package mulneg_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_Q1   = 3'b001,
    ST_Q2   = 3'b010,
    ST_Q3   = 3'b011,
    ST_Q4   = 3'b100
  } exec_state_t;

  typedef enum logic [1:0] {
    OPK_NOP  = 2'b00,
    OPK_MULL = 2'b01,
    OPK_MULF = 2'b10,
    OPK_NEG  = 2'b11
  } op_kind_t;

endpackage

/* core/exec_data_ram.sv */
/*
  Byte-wide data memory with one synchronous port and registered read data.
  Assumes a single clock and that reads and writes never collide by design.
*/
`timescale 1ns/10ps
`include "mulneg_params.svh"

module exec_data_ram (
  // Clock
  input  wire logic        pclk,
  // Port
  input  wire logic [11:0] addr,
  input  wire logic        we,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);

  logic [7:0] mem [0:`MEM_DEPTH-1];

  // No reset: contents are data, loaded by software before use.
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule // exec_data_ram

/* core/multiply_negate_exec_unit.sv */
/*
  Execution unit for the literal multiply, file multiply, negate and
  no-operation instructions, with its working register, bank select,
  status flags, product pair and data memory behind an APB slave.
  Assumes a single APB master on pclk and that software issues opcodes
  by writing the instruction register.
*/
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "mulneg_params.svh"

module multiply_negate_exec_unit (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core state seen by the rest of the core
  output logic      [7:0]  product_high_byte,
  output logic      [7:0]  product_low_byte,
  output logic      [4:0]  status_flags,
  output logic             busy
);
  import mulneg_pkg::*;

  // ****************************************
  // State
  // ****************************************
  exec_state_t state_r;
  op_kind_t    kind_r;
  logic [15:0] op_r;
  logic [11:0] addr_r;
  logic [7:0]  opnd_r;
  logic [7:0]  w_r;
  logic [3:0]  bank_select_register;
  logic [4:0]  flags_r;
  logic [7:0]  prod_lo_r;
  logic [7:0]  prod_hi_r;
  logic        ext_r;
  logic [11:0] idx_base_r;
  logic [11:0] mem_addr_r;
  logic        mem_ok_r;
  logic [7:0]  mem_rdata;

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic [11:0] eff_addr(input logic [15:0] op,
                                           input logic [3:0]  bank,
                                           input logic        ext,
                                           input logic [11:0] base);
    logic [7:0] f;
    f = op[7:0];
    if (op[8]) begin
      eff_addr = {bank, f};
    end else if (ext && (f <= `LIT_LIMIT)) begin
      eff_addr = base + {4'h0, f};
    end else if (f < `ACC_SPLIT) begin
      eff_addr = {`ACC_LOW_BANK, f};
    end else begin
      eff_addr = {`ACC_HIGH_BANK, f};
    end
  endfunction

  wire logic        is_mull = pwdata[15:8] == `OPC_MULL_HI;
  wire logic        is_mulf = pwdata[15:9] == `OPC_MULF_HI;
  wire logic        is_neg  = pwdata[15:9] == `OPC_NEG_HI;
  // Zero and Fxxx are both accepted as no-operations; anything else also runs as one but is flagged illegal.
  wire logic        is_nop  = (pwdata[15:0] == 16'h0000) ||
                              (pwdata[15:12] == `OPC_NOP_TOP);
  wire op_kind_t    kind_in = is_mull ? OPK_MULL :
                              is_mulf ? OPK_MULF :
                              is_neg  ? OPK_NEG  : OPK_NOP;
  wire logic        illegal = !(is_mull || is_mulf || is_neg || is_nop);
  logic             illegal_r;

  // ****************************************
  // APB decode
  // ****************************************
  wire logic        exec_busy = state_r != ST_IDLE;
  wire logic        access    = psel && penable;
  wire logic        sel_mdata = paddr == `OFS_MEM_DATA;
  // Everything waits while an instruction runs, so operands cannot move
  // under it; memory data also waits for the read port to settle.
  wire logic        grant     = !exec_busy && (!sel_mdata || mem_ok_r);
  wire logic        done      = access && pready;
  wire logic        wr_done   = done && pwrite;
  wire logic        mapped    = (paddr[1:0] == 2'b00) &&
                                (paddr <= `OFS_IDX_BASE);
  wire logic        issue     = wr_done && (paddr == `OFS_INSTR);

  logic [31:0] rd_mux;
  always_comb begin
    unique case (paddr)
      `OFS_CTRL:     rd_mux = {31'h0, ext_r};
      `OFS_WREG:     rd_mux = {24'h0, w_r};
      `OFS_BANKSEL:  rd_mux = {28'h0, bank_select_register};
      `OFS_STATUS:   rd_mux = {27'h0, flags_r};
      `OFS_PROD_LO:  rd_mux = {24'h0, prod_lo_r};
      `OFS_PROD_HI:  rd_mux = {24'h0, prod_hi_r};
      `OFS_INSTR:    rd_mux = {14'h0, illegal_r, exec_busy, op_r};
      `OFS_MEM_ADDR: rd_mux = {20'h0, mem_addr_r};
      `OFS_MEM_DATA: rd_mux = {24'h0, mem_rdata};
      `OFS_IDX_BASE: rd_mux = {20'h0, idx_base_r};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Datapath
  // ****************************************
  wire logic [15:0] product   = w_r * opnd_r;
  wire logic [8:0]  neg_sum   = {1'b0, ~opnd_r} + 9'h001;
  wire logic [4:0]  neg_nib   = {1'b0, ~opnd_r[3:0]} + 5'h01;
  wire logic [7:0]  neg_res   = neg_sum[7:0];
  wire logic [4:0]  neg_flags = {neg_res[7], (opnd_r == 8'h80),
                                 (neg_res == 8'h00), neg_nib[4],
                                 neg_sum[8]};
  wire logic        in_q4     = state_r == ST_Q4;
  wire logic        is_mul_r  = (kind_r == OPK_MULL) || (kind_r == OPK_MULF);
  // Only negate writes memory from the execution side.
  wire logic        mem_we    = (in_q4 && kind_r == OPK_NEG) ||
                                (!exec_busy && wr_done && sel_mdata);
  wire logic [11:0] ram_addr  = exec_busy ? addr_r : mem_addr_r;
  wire logic [7:0]  ram_wdata = exec_busy ? neg_res : pwdata[7:0];

  exec_data_ram u_ram (
    .pclk  (pclk),
    .addr  (ram_addr),
    .we    (mem_we),
    .wdata (ram_wdata),
    .rdata (mem_rdata)
  );

  // ****************************************
  // Sequencer: Q1 decode, Q2 read, Q3 process, Q4 write
  // ****************************************
  exec_state_t state_nxt;
  always_comb begin
    unique case (state_r)
      ST_IDLE: state_nxt = issue ? ST_Q1 : ST_IDLE;
      ST_Q1:   state_nxt = ST_Q2;
      ST_Q2:   state_nxt = ST_Q3;
      ST_Q3:   state_nxt = ST_Q4;
      ST_Q4:   state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= ST_IDLE;
      kind_r    <= OPK_NOP;
      op_r      <= `RST_OP;
      illegal_r <= 1'b0;
      addr_r    <= `RST_ADDR;
      opnd_r    <= `RST_BYTE;
    end else begin
      state_r <= state_nxt;
      if (issue) begin
        kind_r    <= kind_in;
        op_r      <= pwdata[15:0];
        illegal_r <= illegal;
      end
      if (state_r == ST_Q1) begin
        addr_r <= eff_addr(op_r, bank_select_register, ext_r, idx_base_r);
      end
      if (state_r == ST_Q3) begin
        opnd_r <= (kind_r == OPK_MULL) ? op_r[7:0] : mem_rdata;
      end
    end
  end

  // Architectural registers. Only the Q4 phase changes them from the
  // execution side; a no-operation leaves every one alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_r                  <= `RST_BYTE;
      bank_select_register <= 4'h0;
      flags_r              <= `RST_FLAGS;
      prod_lo_r            <= `RST_BYTE;
      prod_hi_r            <= `RST_BYTE;
      ext_r                <= 1'b0;
      idx_base_r           <= `RST_ADDR;
      mem_addr_r           <= `RST_ADDR;
    end else begin
      if (in_q4 && is_mul_r) begin
        prod_hi_r <= product[15:8];
        prod_lo_r <= product[7:0];
      end
      if (in_q4 && kind_r == OPK_NEG) begin
        flags_r <= neg_flags;
      end
      if (wr_done) begin
        unique case (paddr)
          `OFS_CTRL:     ext_r <= pwdata[`CTRL_EXT_BIT];
          `OFS_WREG:     w_r <= pwdata[7:0];
          `OFS_BANKSEL:  bank_select_register <= pwdata[3:0];
          `OFS_STATUS:   flags_r <= pwdata[4:0];
          `OFS_MEM_ADDR: mem_addr_r <= pwdata[11:0];
          `OFS_IDX_BASE: idx_base_r <= pwdata[11:0];
          default:       ;
        endcase
      end
    end
  end

  // APB answer, one cycle into the access phase at the earliest.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      mem_ok_r <= 1'b0;
      busy     <= 1'b0;
    end else begin
      pready   <= access && !pready && grant;
      if (access && !pready && grant) begin
        prdata  <= (pwrite || !mapped) ? 32'h0000_0000 : rd_mux;
        pslverr <= !mapped;
      end
      mem_ok_r <= !exec_busy && !issue &&
                  !(wr_done && (paddr == `OFS_MEM_ADDR || sel_mdata));
      busy     <= state_nxt != ST_IDLE;
    end
  end

  assign product_high_byte = prod_hi_r;
  assign product_low_byte  = prod_lo_r;
  assign status_flags      = flags_r;

  // ****************************************
  // Checks
  // ****************************************
  property p_mull_prod;
    @(posedge pclk) disable iff (!presetn)
    (in_q4 && kind_r == OPK_MULL) |=>
      {prod_hi_r, prod_lo_r} == $past(w_r) * $past(op_r[7:0]);
  endproperty
  a_mull_prod: assert property (p_mull_prod)
    else $error("literal product wrong");

  property p_mull_w;
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_Q1 && kind_r == OPK_MULL) |-> ##4 $stable(w_r);
  endproperty
  a_mull_w: assert property (p_mull_w)
    else $error("working register changed by multiply");

  property p_mulf_prod;
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_Q3 && kind_r == OPK_MULF) |=> ##1
      {prod_hi_r, prod_lo_r} == $past(w_r, 2) * $past(mem_rdata, 2);
  endproperty
  a_mulf_prod: assert property (p_mulf_prod)
    else $error("file product wrong");

  property p_mulf_keep;
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_Q4 && kind_r == OPK_MULF) |-> !mem_we;
  endproperty
  a_mulf_keep: assert property (p_mulf_keep)
    else $error("file multiply wrote memory");

  property p_mul_flags;
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_Q1 && is_mul_r) |-> ##4 flags_r == $past(flags_r, 4);
  endproperty
  a_mul_flags: assert property (p_mul_flags)
    else $error("multiply changed flags");

  property p_bank_addr;
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_Q1 && kind_r != OPK_MULL && op_r[8]) |=>
      addr_r == {$past(bank_select_register), $past(op_r[7:0])};
  endproperty
  a_bank_addr: assert property (p_bank_addr)
    else $error("banked address wrong");

  property p_idx_addr;
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_Q1 && !op_r[8] && ext_r && op_r[7:0] <= 8'h5F) |=>
      addr_r == $past(idx_base_r) + {4'h0, $past(op_r[7:0])};
  endproperty
  a_idx_addr: assert property (p_idx_addr)
    else $error("indexed address wrong");

  property p_neg_write;
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_Q3 && kind_r == OPK_NEG) |=>
      mem_we && ram_addr == addr_r &&
      ram_wdata == 8'(~$past(mem_rdata) + 8'h01);
  endproperty
  a_neg_write: assert property (p_neg_write)
    else $error("negate result wrong");

  property p_neg_zero;
    @(posedge pclk) disable iff (!presetn)
    (in_q4 && kind_r == OPK_NEG) |=>
      flags_r[`FLG_Z] == ($past(opnd_r) == 8'h00) &&
      flags_r[`FLG_C] == flags_r[`FLG_Z];
  endproperty
  a_neg_zero: assert property (p_neg_zero)
    else $error("negate flags wrong");

  property p_nop_quiet;
    @(posedge pclk) disable iff (!presetn)
    (state_r == ST_Q1 && kind_r == OPK_NOP) |->
      (!mem_we)[*4] ##1 ($stable(prod_lo_r) && $stable(flags_r));
  endproperty
  a_nop_quiet: assert property (p_nop_quiet)
    else $error("no-operation changed state");

  property p_four_phase;
    @(posedge pclk) disable iff (!presetn)
    issue |=> state_r == ST_Q1 ##1 state_r == ST_Q2 ##1
      state_r == ST_Q3 ##1 state_r == ST_Q4 ##1 state_r == ST_IDLE;
  endproperty
  a_four_phase: assert property (p_four_phase)
    else $error("phase sequence wrong");

  c_mull: cover property (@(posedge pclk) in_q4 && kind_r == OPK_MULL);
  c_mulf: cover property (@(posedge pclk) in_q4 && kind_r == OPK_MULF);
  c_neg:  cover property (@(posedge pclk) in_q4 && kind_r == OPK_NEG);
  c_nop:  cover property (@(posedge pclk) in_q4 && kind_r == OPK_NOP);

endmodule // multiply_negate_exec_unit

/* sim/core_host_model.sv */
/*
  APB master standing for the decoder side of the unit.
  Assumes xfer is called just after a rising edge of pclk.
*/
`timescale 1ns/10ps

module core_host_model (
  // Clock
  input  wire logic        pclk,
  // Requests
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  // Answers
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end

  // Released write data is inverted so no one can live on a stale value.
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e, output logic ok);
    ok = 1'b0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        ok = 1'b1;
        q  = prdata;
        e  = pslverr;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
    @(posedge pclk);
  endtask
endmodule // core_host_model

/* sim/multiply_negate_exec_unit_tb.sv */
/*
  Self-checking bench of the multiply and negate unit over APB.
  Assumes the package, header and design are compiled first.
*/
`timescale 1ns/10ps
`include "mulneg_params.svh"

module multiply_negate_exec_unit_tb;
  import mulneg_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  prod_hi;
  logic [7:0]  prod_lo;
  logic [4:0]  flags;
  logic        busy;
  int          fail_count = 0;
  int          n_checks = 0;

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  multiply_negate_exec_unit u_multiply_negate_exec_unit (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .product_high_byte(prod_hi),
    .product_low_byte(prod_lo), .status_flags(flags), .busy(busy)
  );

  core_host_model u_core_host_model (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
  );

  task automatic wrap_up;
    $display("Checks %0d, errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // A transfer that never answers ends the run at once.
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    logic ok;
    u_core_host_model.xfer(wr, a, d, q, e, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    bus(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    bus(1'b0, a, 32'h0, q, e);
  endtask

  task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
    wr(`OFS_MEM_ADDR, {20'h0, a});
    wr(`OFS_MEM_DATA, {24'h0, d});
  endtask

  task automatic mem_rd(input logic [11:0] a, output logic [31:0] q);
    wr(`OFS_MEM_ADDR, {20'h0, a});
    rd(`OFS_MEM_DATA, q);
  endtask

  // Busy is counted from the edge after the issuing write completes.
  task automatic exec(input logic [15:0] op);
    int cyc;
    wr(`OFS_INSTR, {16'h0, op});
    for (cyc = 0; busy === 1'b1 && cyc < 9; cyc++)
      @(posedge pclk);
    chk("busy cycles", 32'd4, 32'(cyc));
  endtask

  task automatic s_regs;
    logic [31:0] q;
    logic        e;
    rd(`OFS_WREG, q);
    chk("w reset", 32'h0, q);
    rd(`OFS_STATUS, q);
    chk("flags reset", 32'h0, q);
    wr(`OFS_PROD_LO, 32'hFF);
    rd(`OFS_PROD_LO, q);
    chk("product read only", 32'h0, q);
    bus(1'b0, 12'h0FC, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
  endtask

  task automatic s_mull;
    logic [31:0] q;
    logic [15:0] p;
    p = 16'(8'hE2) * 16'(8'hC4);
    wr(`OFS_WREG, 32'hE2);
    wr(`OFS_STATUS, 32'h15);
    exec(16'h0DC4);
    chk("literal product", {16'h0, p}, {16'h0, prod_hi, prod_lo});
    rd(`OFS_PROD_HI, q);
    chk("high register", {24'h0, p[15:8]}, q);
    rd(`OFS_WREG, q);
    chk("w kept", 32'hE2, q);
    exec(16'h0D00);
    chk("zero product", 32'h0, {16'h0, prod_hi, prod_lo});
    chk("flags kept", 32'h15, {27'h0, flags});
  endtask

  task automatic s_mulf;
    logic [15:0] op [6] = '{16'h03A5, 16'h0220, 16'h0270,
                            16'h0210, 16'h025F, 16'h0260};
    logic [11:0] ad [6] = '{12'h3A5, 12'h020, 12'hF70,
                            12'h000, 12'h04F, 12'hF60};
    logic [31:0] q;
    logic [15:0] p;
    logic [7:0]  v;
    wr(`OFS_WREG, 32'hC4);
    wr(`OFS_BANKSEL, 32'h3);
    wr(`OFS_IDX_BASE, 32'hFF0);
    wr(`OFS_STATUS, 32'h0A);
    for (int i = 0; i < 6; i++) begin
      v = 8'hB5 + 8'(i);
      p = 16'(8'hC4) * 16'(v);
      wr(`OFS_CTRL, {31'h0, i > 2});
      mem_wr(ad[i], v);
      exec(op[i]);
      chk("file product", {16'h0, p}, {16'h0, prod_hi, prod_lo});
      mem_rd(ad[i], q);
      chk("file kept", {24'h0, v}, q);
      chk("flags kept", 32'h0A, {27'h0, flags});
    end
    rd(`OFS_WREG, q);
    chk("w kept", 32'hC4, q);
  endtask

  task automatic s_neg;
    logic [7:0]  v [4] = '{8'h3A, 8'h80, 8'h00, 8'h10};
    logic [7:0]  r;
    logic [4:0]  f;
    logic [31:0] q;
    wr(`OFS_BANKSEL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      r = ~v[i] + 8'h01;
      f = {r[7], v[i] == 8'h80, r == 8'h00, v[i][3:0] == 4'h0,
           v[i] == 8'h00};
      mem_wr(12'h340 + 12'(i), v[i]);
      exec(16'h6D40 + 16'(i));
      mem_rd(12'h340 + 12'(i), q);
      chk("negated byte", {24'h0, r}, q);
      chk("negate flags", {27'h0, f}, {27'h0, flags});
    end
  endtask

  task automatic s_nop;
    logic [15:0] op [3] = '{16'h0000, 16'hF3A5, 16'hFFA5};
    logic [31:0] q;
    wr(`OFS_WREG, 32'h5A);
    exec(16'h0D03);
    wr(`OFS_STATUS, 32'h0A);
    mem_wr(12'h3A5, 8'h77);
    for (int i = 0; i < 3; i++) begin
      exec(op[i]);
      chk("product idle", 32'h10E, {16'h0, prod_hi, prod_lo});
      chk("flags idle", 32'h0A, {27'h0, flags});
      mem_rd(12'h3A5, q);
      chk("memory idle", 32'h77, q);
      rd(`OFS_WREG, q);
      chk("w idle", 32'h5A, q);
    end
    exec(16'h1234);
    chk("product after unknown", 32'h10E, {16'h0, prod_hi, prod_lo});
    rd(`OFS_INSTR, q);
    chk("unknown opcode flagged", 32'h0002_1234, q);
  endtask

  initial begin
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs();
    s_mull();
    s_mulf();
    s_neg();
    s_nop();
    wrap_up();
  end
endmodule // multiply_negate_exec_unit_tb
